// ### rtl/flash_host_pkg.sv
// Constants, register map and step record for the flash host controller.
// Assumes a 125 MHz mclk and a parallel flash with an active-low busy pin.
package flash_host_pkg;
   // Clock rate and bus timing
   localparam int CLK_MHZ = 125;
   localparam int WE_PULSE_NS = 50;
   localparam int WE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_ACCESS_NS = 100;
   localparam int RD_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_LAT = 4;
   localparam int RD_TOTAL = RD_CYC + SYNC_LAT;
   localparam int BUSY_SETTLE_NS = 500;
   localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SUSPEND_MAX_US = 20;
   localparam int SUSPEND_CYC = SUSPEND_MAX_US * CLK_MHZ;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_WDATA = 8'h0c;
   localparam logic [7:0] REG_PWD_LO = 8'h10;
   localparam logic [7:0] REG_PWD_HI = 8'h14;
   localparam logic [7:0] REG_RD_LO = 8'h18;
   localparam logic [7:0] REG_RD_HI = 8'h1c;
   localparam logic [7:0] REG_STATUS = 8'h20;

   // Field positions and reset values
   localparam int CTRL_BUS32_BIT = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   localparam int ST_SUSP_BIT = 3;
   localparam int ST_READY_BIT = 4;
   localparam int ST_MARGIN_BIT = 5;
   localparam int TOGGLE_BIT_POS = 6;
   localparam int SUSPEND_TOGGLE_POS = 2;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [63:0] PWD_RST = 64'hffff_ffff_ffff_ffff;

   // Host command opcodes written to REG_CMD
   localparam logic [3:0] OPC_SUSPEND = 4'h1;
   localparam logic [3:0] OPC_RESUME = 4'h2;
   localparam logic [3:0] OPC_PWD_PROG = 4'h3;
   localparam logic [3:0] OPC_PWD_VERIFY = 4'h4;
   localparam logic [3:0] OPC_PWD_LOCK = 4'h5;
   localparam logic [3:0] OPC_PERSIST_LOCK = 4'h6;
   localparam logic [3:0] OPC_READ_RESET = 4'h7;
   localparam logic [3:0] OPC_READ = 4'h8;
   localparam logic [3:0] OPC_WRITE = 4'h9;

   // Flash command codes
   localparam logic [7:0] CODE_SUSPEND = 8'hb0;
   localparam logic [7:0] CODE_PWD_PROG = 8'h38;

   typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_WAIT_RDY, OP_WAIT_TIME} op_kind_t;

   typedef struct packed {
      op_kind_t kind;
      logic [23:0] addr;
      logic [31:0] data;
      logic last;
   } step_t;
endpackage

// ### rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_dout;

   // A change counts once stages two and three agree
   always_comb
   begin
      next_dout = dout;
      if (s2 == s3)
      begin
         next_dout = s3;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         dout <= RST_VAL;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= next_dout;
      end
   end
endmodule // pin_sync
`default_nettype wire

// ### rtl/flash_host_ctrl.sv
// Host controller driving a parallel NOR flash: erase suspend/resume and password commands.
// Assumes an APB master for software and a flash with an active-low busy pin.
// Behaviour
// - Suspend writes code b0 with the erasing bank's address.
// - Resume writes its code with the bank address; extra resumes ignored.
// - Password is 64 bits: four portions in 16-bit mode, two in 32-bit.
// - Each portion: unlock, code 38, then portion address and data.
// - Password programming shows status on reads; finish with Read/Reset.
// - Reissue a locking bit program when readback shows no margin.
// - After a locking bit program, write Read/Reset.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl #(
   parameter int ADDR_W = 22,
   parameter int READY_TIMEOUT = 1000000,
   parameter logic [1:0] MAX_RETRY = 2'h2,
   parameter int MARGIN_BIT = 0,
   parameter logic [23:0] UNLOCK1_ADDR = 24'h000555,
   parameter logic [7:0] UNLOCK1_DATA = 8'haa,
   parameter logic [23:0] UNLOCK2_ADDR = 24'h0002aa,
   parameter logic [7:0] UNLOCK2_DATA = 8'h55,
   parameter logic [7:0] CODE_RESUME = 8'h30,
   parameter logic [7:0] CODE_READ_RESET = 8'hf0,
   parameter logic [7:0] CODE_PWD_VERIFY = 8'hc8,
   parameter logic [7:0] CODE_PWD_LOCK = 8'h28,
   parameter logic [7:0] CODE_PERSIST_LOCK = 8'h48
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [31:0] data_bus_out,
   output logic data_bus_oe,
   input wire logic [31:0] data_bus_in,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic bus32_select,
   input wire logic busy_indicator_pin_n
);
   typedef enum {S_IDLE, S_FETCH, S_W_SETUP, S_W_PULSE, S_W_HOLD, S_READ, S_WAIT_RDY,
      S_WAIT_TIME, S_NEXT} state_t;

   state_t state, next_state;
   logic [3:0] cmd, next_cmd;
   logic [2:0] step, next_step;
   logic [1:0] portion, next_portion;
   logic [1:0] retries, next_retries;
   logic [31:0] cnt, next_cnt;
   logic [ADDR_W-1:0] addr_reg, next_addr_reg;
   logic [31:0] wdata_reg, next_wdata_reg;
   logic [63:0] pwd, next_pwd;
   logic [63:0] rd, next_rd;
   logic bus32, next_bus32;
   logic st_busy, next_st_busy;
   logic st_done, next_st_done;
   logic st_err, next_st_err;
   logic st_susp, next_st_susp;
   logic st_margin, next_st_margin;
   logic margin_ok, next_margin_ok;
   logic [ADDR_W-1:0] next_flash_addr;
   logic [31:0] next_data_bus_out;
   logic next_data_bus_oe, next_ce_n, next_oe_n, next_we_n;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic [31:0] dq_s;
   logic ready_s;
   logic wr_hit;
   logic [1:0] last_portion;
   logic [31:0] dq_w;
   logic [31:0] portion_data;
   flash_host_pkg::step_t cur;

   pin_sync #(.W(32), .RST_VAL(32'h0000_0000)) u_dq_sync (
      .mclk(mclk),
      .rst(rst),
      .din(data_bus_in),
      .dout(dq_s)
   );

   pin_sync #(.W(1), .RST_VAL(1'b1)) u_busy_sync (
      .mclk(mclk),
      .rst(rst),
      .din(busy_indicator_pin_n),
      .dout(ready_s)
   );

   function automatic flash_host_pkg::step_t mk(input flash_host_pkg::op_kind_t k,
      input logic [23:0] a, input logic [31:0] d, input logic l);
      flash_host_pkg::step_t r;
      r.kind = k;
      r.addr = a;
      r.data = d;
      r.last = l;
      return r;
   endfunction

   assign wr_hit = psel & penable & pready & pwrite;
   assign last_portion = bus32 ? 2'h1 : 2'h3;
   assign dq_w = bus32 ? dq_s : {16'h0000, dq_s[15:0]};
   assign portion_data = bus32 ? pwd[{portion[0], 5'h00} +: 32]
      : {16'h0000, pwd[{portion, 4'h0} +: 16]};

   // Step table of each host command
   always_comb
   begin
      logic [23:0] a;
      logic [23:0] pa;
      a = 24'(addr_reg);
      pa = {22'h000000, portion};
      cur = mk(flash_host_pkg::OP_WRITE, UNLOCK1_ADDR, 32'(UNLOCK1_DATA), 1'b0);
      if (step == 3'h1)
      begin
         cur = mk(flash_host_pkg::OP_WRITE, UNLOCK2_ADDR, 32'(UNLOCK2_DATA), 1'b0);
      end
      case (cmd)
         flash_host_pkg::OPC_SUSPEND:
            case (step)
               3'h0: cur = mk(flash_host_pkg::OP_WRITE, a, 32'(flash_host_pkg::CODE_SUSPEND),
                  1'b0);
               3'h1: cur = mk(flash_host_pkg::OP_WAIT_TIME, a, 32'h0, 1'b0);
               3'h2: cur = mk(flash_host_pkg::OP_READ, a, 32'h0, 1'b0);
               default: cur = mk(flash_host_pkg::OP_READ, a, 32'h0, 1'b1);
            endcase
         flash_host_pkg::OPC_RESUME:
            cur = mk(flash_host_pkg::OP_WRITE, a, 32'(CODE_RESUME), 1'b1);
         flash_host_pkg::OPC_PWD_PROG:
            case (step)
               3'h0, 3'h1: ;
               3'h2: cur = mk(flash_host_pkg::OP_WRITE, UNLOCK1_ADDR,
                  32'(flash_host_pkg::CODE_PWD_PROG), 1'b0);
               3'h3: cur = mk(flash_host_pkg::OP_WRITE, pa, portion_data, 1'b0);
               3'h4: cur = mk(flash_host_pkg::OP_WAIT_RDY, a, 32'h0, 1'b0);
               default: cur = mk(flash_host_pkg::OP_WRITE, a, 32'(CODE_READ_RESET),
                  1'b1);
            endcase
         flash_host_pkg::OPC_PWD_VERIFY:
            case (step)
               3'h0, 3'h1: ;
               3'h2: cur = mk(flash_host_pkg::OP_WRITE, UNLOCK1_ADDR, 32'(CODE_PWD_VERIFY),
                  1'b0);
               3'h3: cur = mk(flash_host_pkg::OP_READ, pa, 32'h0, 1'b0);
               default: cur = mk(flash_host_pkg::OP_WRITE, a, 32'(CODE_READ_RESET), 1'b1);
            endcase
         flash_host_pkg::OPC_PWD_LOCK, flash_host_pkg::OPC_PERSIST_LOCK:
            case (step)
               3'h0, 3'h1: ;
               3'h2: cur = mk(flash_host_pkg::OP_WRITE, UNLOCK1_ADDR,
                  (cmd == flash_host_pkg::OPC_PWD_LOCK) ? 32'(CODE_PWD_LOCK)
                  : 32'(CODE_PERSIST_LOCK), 1'b0);
               3'h3: cur = mk(flash_host_pkg::OP_WRITE, a, wdata_reg, 1'b0);
               3'h4: cur = mk(flash_host_pkg::OP_WAIT_RDY, a, 32'h0, 1'b0);
               3'h5: cur = mk(flash_host_pkg::OP_READ, a, 32'h0, 1'b0);
               default: cur = mk(flash_host_pkg::OP_WRITE, a, 32'(CODE_READ_RESET),
                  1'b1);
            endcase
         flash_host_pkg::OPC_READ_RESET:
            cur = mk(flash_host_pkg::OP_WRITE, a, 32'(CODE_READ_RESET), 1'b1);
         flash_host_pkg::OPC_READ:
            cur = mk(flash_host_pkg::OP_READ, a, 32'h0, 1'b1);
         default:
            cur = mk(flash_host_pkg::OP_WRITE, a, wdata_reg, 1'b1);
      endcase
   end

   // APB slave answer: pready one cycle into the access phase
   always_comb
   begin
      next_pready = psel & penable & ~pready;
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (psel & penable & ~pready)
      begin
         case (paddr)
            flash_host_pkg::REG_CTRL: next_prdata = {31'h0, bus32};
            flash_host_pkg::REG_CMD: next_prdata = {28'h0, cmd};
            flash_host_pkg::REG_ADDR: next_prdata = 32'(addr_reg);
            flash_host_pkg::REG_WDATA: next_prdata = wdata_reg;
            flash_host_pkg::REG_PWD_LO: next_prdata = pwd[31:0];
            flash_host_pkg::REG_PWD_HI: next_prdata = pwd[63:32];
            flash_host_pkg::REG_RD_LO: next_prdata = rd[31:0];
            flash_host_pkg::REG_RD_HI: next_prdata = rd[63:32];
            flash_host_pkg::REG_STATUS: next_prdata = {26'h0, st_margin, ready_s, st_susp,
               st_err, st_done, st_busy};
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   // Command engine and software registers
   always_comb
   begin
      next_state = state;
      next_cmd = cmd;
      next_step = step;
      next_portion = portion;
      next_retries = retries;
      next_cnt = cnt + 32'h1;
      next_addr_reg = addr_reg;
      next_wdata_reg = wdata_reg;
      next_pwd = pwd;
      next_rd = rd;
      next_bus32 = bus32;
      next_st_busy = st_busy;
      next_st_done = st_done;
      next_st_err = st_err;
      next_st_susp = st_susp;
      next_st_margin = st_margin;
      next_margin_ok = margin_ok;
      next_flash_addr = flash_addr;
      next_data_bus_out = data_bus_out;
      next_data_bus_oe = data_bus_oe;
      next_ce_n = flash_ce_n;
      next_oe_n = flash_oe_n;
      next_we_n = flash_we_n;
      if (wr_hit && !st_busy)
      begin
         case (paddr)
            flash_host_pkg::REG_CTRL: next_bus32 = pwdata[flash_host_pkg::CTRL_BUS32_BIT];
            flash_host_pkg::REG_ADDR: next_addr_reg = pwdata[ADDR_W-1:0];
            flash_host_pkg::REG_WDATA: next_wdata_reg = pwdata;
            flash_host_pkg::REG_PWD_LO: next_pwd[31:0] = pwdata;
            flash_host_pkg::REG_PWD_HI: next_pwd[63:32] = pwdata;
            flash_host_pkg::REG_CMD:
               if (pwdata[3:0] >= flash_host_pkg::OPC_SUSPEND
                  && pwdata[3:0] <= flash_host_pkg::OPC_WRITE)
               begin
                  next_cmd = pwdata[3:0];
                  next_step = 3'h0;
                  next_portion = 2'h0;
                  next_retries = MAX_RETRY;
                  next_st_busy = 1'b1;
                  next_st_done = 1'b0;
                  next_st_err = 1'b0;
                  next_st_margin = 1'b0;
                  next_state = S_FETCH;
               end
            default: ;
         endcase
      end
      unique case (state)
         S_IDLE: ;
         S_FETCH:
         begin
            next_cnt = 32'h0;
            next_flash_addr = cur.addr[ADDR_W-1:0];
            next_data_bus_out = cur.data;
            unique case (cur.kind)
               flash_host_pkg::OP_WRITE:
               begin
                  next_ce_n = 1'b0;
                  next_data_bus_oe = 1'b1;
                  next_state = S_W_SETUP;
               end
               flash_host_pkg::OP_READ:
               begin
                  next_ce_n = 1'b0;
                  next_oe_n = 1'b0;
                  next_state = S_READ;
               end
               flash_host_pkg::OP_WAIT_RDY: next_state = S_WAIT_RDY;
               flash_host_pkg::OP_WAIT_TIME: next_state = S_WAIT_TIME;
            endcase
         end
         S_W_SETUP:
         begin
            next_we_n = 1'b0;
            next_cnt = 32'h0;
            next_state = S_W_PULSE;
         end
         S_W_PULSE:
            if (cnt == 32'(flash_host_pkg::WE_CYC - 1))
            begin
               next_we_n = 1'b1;
               next_state = S_W_HOLD;
            end
         S_W_HOLD:
         begin
            next_ce_n = 1'b1;
            next_data_bus_oe = 1'b0;
            next_state = S_NEXT;
         end
         S_READ:
            if (cnt == 32'(flash_host_pkg::RD_TOTAL - 1))
            begin
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
               next_state = S_NEXT;
               if (cmd == flash_host_pkg::OPC_PWD_VERIFY)
               begin
                  if (bus32)
                  begin
                     next_rd[{portion[0], 5'h00} +: 32] = dq_w;
                  end
                  else
                  begin
                     next_rd[{portion, 4'h0} +: 16] = dq_w[15:0];
                  end
               end
               else if (cmd == flash_host_pkg::OPC_SUSPEND && step == 3'h2)
               begin
                  next_rd = {32'h0, dq_w};
               end
               else if (cmd == flash_host_pkg::OPC_SUSPEND)
               begin
                  next_rd[63:32] = dq_w;
                  next_st_susp = (dq_w[flash_host_pkg::TOGGLE_BIT_POS]
                     == rd[flash_host_pkg::TOGGLE_BIT_POS])
                     && (dq_w[flash_host_pkg::SUSPEND_TOGGLE_POS]
                     != rd[flash_host_pkg::SUSPEND_TOGGLE_POS]);
               end
               else if (cmd == flash_host_pkg::OPC_READ)
               begin
                  next_rd = {32'h0, dq_w};
               end
               else
               begin
                  next_margin_ok = dq_w[MARGIN_BIT];
               end
            end
         S_WAIT_RDY:
            if (cnt >= 32'(flash_host_pkg::BUSY_SETTLE_CYC) && ready_s)
            begin
               next_state = S_NEXT;
            end
            else if (cnt == 32'(READY_TIMEOUT))
            begin
               next_st_err = 1'b1;
               next_st_busy = 1'b0;
               next_st_done = 1'b1;
               next_state = S_IDLE;
            end
         S_WAIT_TIME:
            if (cnt == 32'(flash_host_pkg::SUSPEND_CYC - 1))
            begin
               next_state = S_NEXT;
            end
         S_NEXT:
         begin
            next_state = S_FETCH;
            next_step = step + 3'h1;
            if (cmd == flash_host_pkg::OPC_PWD_PROG && step == 3'h4
               && portion != last_portion)
            begin
               next_portion = portion + 2'h1;
               next_step = 3'h0;
            end
            else if (cmd == flash_host_pkg::OPC_PWD_VERIFY && step == 3'h3
               && portion != last_portion)
            begin
               next_portion = portion + 2'h1;
               next_step = 3'h3;
            end
            else if (step == 3'h5 && !margin_ok && (cmd == flash_host_pkg::OPC_PWD_LOCK
               || cmd == flash_host_pkg::OPC_PERSIST_LOCK))
            begin
               if (retries != 2'h0)
               begin
                  next_retries = retries - 2'h1;
                  next_step = 3'h0;
               end
               else
               begin
                  next_st_margin = 1'b1;
               end
            end
            if (cur.last)
            begin
               if (cmd == flash_host_pkg::OPC_RESUME)
               begin
                  next_st_susp = 1'b0;
               end
               next_st_busy = 1'b0;
               next_st_done = 1'b1;
               next_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state <= S_IDLE;
         cmd <= 4'h0;
         step <= 3'h0;
         portion <= 2'h0;
         retries <= 2'h0;
         cnt <= flash_host_pkg::REG_RST;
         addr_reg <= '0;
         wdata_reg <= flash_host_pkg::REG_RST;
         pwd <= flash_host_pkg::PWD_RST;
         rd <= 64'h0;
         bus32 <= 1'b0;
         st_busy <= 1'b0;
         st_done <= 1'b0;
         st_err <= 1'b0;
         st_susp <= 1'b0;
         st_margin <= 1'b0;
         margin_ok <= 1'b0;
         flash_addr <= '0;
         data_bus_out <= flash_host_pkg::REG_RST;
         data_bus_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         bus32_select <= 1'b0;
         prdata <= flash_host_pkg::REG_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cmd <= next_cmd;
         step <= next_step;
         portion <= next_portion;
         retries <= next_retries;
         cnt <= next_cnt;
         addr_reg <= next_addr_reg;
         wdata_reg <= next_wdata_reg;
         pwd <= next_pwd;
         rd <= next_rd;
         bus32 <= next_bus32;
         st_busy <= next_st_busy;
         st_done <= next_st_done;
         st_err <= next_st_err;
         st_susp <= next_st_susp;
         st_margin <= next_st_margin;
         margin_ok <= next_margin_ok;
         flash_addr <= next_flash_addr;
         data_bus_out <= next_data_bus_out;
         data_bus_oe <= next_data_bus_oe;
         flash_ce_n <= next_ce_n;
         flash_oe_n <= next_oe_n;
         flash_we_n <= next_we_n;
         bus32_select <= next_bus32;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end
endmodule // flash_host_ctrl
`default_nettype wire

// ### bench/flash_host_ctrl_monitor.sv
// Concurrent checks on the APB slave and flash strobes of the host controller.
// Assumes it is bound onto flash_host_ctrl; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic data_bus_oe,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence we_low_s;
      !flash_we_n [*7];
   endsequence
   a_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not answered");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_unmapped_err: assert property (pready && paddr > 8'h20 |-> pslverr) else $error("no pslverr");
   a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
   a_we_width: assert property ($fell(flash_we_n) |-> we_low_s ##1 flash_we_n)
      else $error("write pulse width");
   a_we_drive: assert property (!flash_we_n
      |-> !flash_ce_n && data_bus_oe && flash_oe_n) else $error("write cycle strobes");
   a_read_float: assert property (!flash_oe_n |-> !data_bus_oe && !flash_ce_n)
      else $error("read cycle strobes");
   a_ce_gap: assert property ($rose(flash_ce_n) |=> flash_ce_n) else $error("chip select gap");
endmodule // flash_host_ctrl_monitor
bind flash_host_ctrl flash_host_ctrl_monitor u_mon (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .data_bus_oe(data_bus_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n));
`default_nettype wire

// ### bench/flash_model.sv
// Behavioural flash: erase suspend state, password store and locking bits.
// Assumes a sector erase runs from power-up; a released bus shows the inverse.
`timescale 1ns/1ps
`default_nettype none
module flash_model (
   input wire logic [21:0] addr,
   input wire logic [31:0] din,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic bus32,
   output logic [31:0] dout,
   output logic busy_n
);
   logic [63:0] pwd = '1;
   logic [7:0] last = 8'h0;
   logic [21:0] bank = 22'h0;
   logic susp = 1'b0;
   logic vfy = 1'b0;
   logic plock = 1'b0;
   logic slock = 1'b0;
   logic st = 1'b0;
   logic busy = 1'b0;
   logic prog;
   logic [31:0] rd;
   assign prog = last == 8'h38 || last == 8'h28 || last == 8'h48;
   assign busy_n = !busy;
   always @(negedge oe_n) st <= !st;
   // Busy pin low for 2 us after each program write
   always
   begin
      @(posedge we_n);
      if (prog)
      begin
         busy = 1'b1;
         #2000 busy = 1'b0;
      end
   end
   always @(posedge we_n)
   begin
      last <= prog ? 8'h0 : din[7:0];
      if (last == 8'h38 && bus32)
         pwd[32*addr[0]+:32] <= pwd[32*addr[0]+:32] & din;
      else if (last == 8'h38)
         pwd[16*addr[1:0]+:16] <= pwd[16*addr[1:0]+:16] & din[15:0];
      else if (last == 8'h28)
         plock <= plock | !slock;
      else if (last == 8'h48)
         slock <= slock | !plock;
      else if (din[7:0] == 8'hb0 && !busy)
      begin
         susp <= 1'b1;
         bank <= addr;
      end
      else if (din[7:0] == 8'h30)
         susp <= 1'b0;
      else if (din[7:0] == 8'hc8)
         vfy <= 1'b1;
      else if (din[7:0] == 8'hf0)
         vfy <= 1'b0;
   end
   always_comb
   begin
      rd = {25'h0, st & !susp, 3'h0, st, 2'h1};
      if (vfy)
         rd = plock ? '1 : bus32 ? pwd[32*addr[0]+:32]
            : {16'h0, pwd[16*addr[1:0]+:16]};
   end
   assign dout = oe_n ? ~rd : rd;
endmodule // flash_model
`default_nettype wire

// ### bench/flash_host_ctrl_tb.sv
// Self-checking bench: APB master and flash model around flash_host_ctrl.
// Assumes the monitor binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, fdin, fdout;
   logic pready, pslverr, err, oe, ce_n, oe_n, we_n, b32, busy_n;
   logic [21:0] faddr;
   logic [63:0] pw, v;
   int miscompares = 0;
   int tests_run = 0;
   flash_host_ctrl #(.READY_TIMEOUT(2000)) DUT (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_addr(faddr), .data_bus_out(fdout),
      .data_bus_oe(oe), .data_bus_in(fdin), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .bus32_select(b32), .busy_indicator_pin_n(busy_n));
   flash_model u_flash (.addr(faddr), .din(fdout), .oe_n(oe_n), .we_n(we_n), .bus32(b32),
      .dout(fdin), .busy_n(busy_n));
   initial forever #4 mclk = ~mclk;
   function automatic logic [63:0] prog_pwd(input logic [63:0] old, input logic [63:0] nw);
      return old & nw;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] op);
      apb(1'b1, 8'h04, {28'h0, op});
      do
      begin
         apb(1'b0, 8'h20, 32'h0);
      end
      while (rd[1] !== 1'b1 || rd[0] !== 1'b0);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      complete_run();
   end
   initial
   begin
      pw = '1;
      v = {$urandom(32'hd793), $urandom};
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h10);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'hffff_ffff);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 8'h08, v[31:0] & 32'h003f_ffff);
      cmd(4'h1);
      chk(rd & 32'h0c, 32'h08);
      chk(32'(u_flash.bank), v[31:0] & 32'h003f_ffff);
      cmd(4'h2);
      chk(rd & 32'h0c, 32'h0);
      cmd(4'h2);
      chk(rd & 32'h0c, 32'h0);
      for (int m = 0; m < 2; m++)
      begin
         v = {$urandom, $urandom};
         pw = prog_pwd(pw, v);
         apb(1'b1, 8'h00, 32'(m));
         apb(1'b1, 8'h10, v[31:0]);
         apb(1'b1, 8'h14, v[63:32]);
         cmd(4'h3);
         cmd(4'h4);
         apb(1'b0, 8'h18, 32'h0);
         chk(rd, pw[31:0]);
         apb(1'b0, 8'h1c, 32'h0);
         chk(rd, pw[63:32]);
      end
      apb(1'b1, 8'h0c, 32'hc8);
      cmd(4'h5);
      chk(rd & 32'h24, 32'h0);
      cmd(4'h4);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'hffff_ffff);
      cmd(4'h6);
      chk(rd & 32'h24, 32'h0);
      cmd(4'h9);
      cmd(4'h8);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'hffff_ffff);
      cmd(4'h7);
      cmd(4'h8);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd & 32'hffff_ffbb, 32'h1);
      complete_run();
   end
endmodule // flash_host_ctrl_tb
`default_nettype wire
